// ---- rtl/adc_seq_defs.svh ----
// constants for the converter sequencer: register offsets, fields, resets, timing
// assumes a 40 MHz core clock and an 8-bit register port
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define CLK_PERIOD_NS 25
`define PASS_PERIOD_MS 1000
`define SAMPLE_PERIOD_US 256
`define SAMPLE_CYCLES ((`SAMPLE_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define PASS_CYCLES ((`PASS_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define TARGET_ADDR_WR 8'hD2
`define TARGET_ADDR_RD 8'hD3
`define REG_CTRL 8'h50
`define REG_AVG_EN 8'h51
`define REG_OFS_EN 8'h52
`define REG_STATUS 8'h53
`define REG_RESULT0 8'h54
`define CTRL_ENABLE_BIT 0
`define CTRL_CONT_BIT 1
`define CTRL_DEPTH_LSB 2
`define CTRL_RANGE_BIT 4
`define CTRL_RESET 8'h00
`define AVG_EN_RESET 8'h00
`define OFS_EN_RESET 8'h00
`define OFS_CHAN_MASK 6'h1A
`define NUM_CHANNELS 6
`define RESULT_BITS 8
`endif

// ---- rtl/adc_seq_pkg.sv ----
// types shared by the sequencer and its helpers
// constants live in adc_seq_defs.svh
package adc_seq_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_WAIT_SAMPLE = 2'b10,
        ST_SLEEP = 2'b11
    } seq_state_e;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
    typedef struct packed {
        logic power_en;
        logic start;
        logic [2:0] channel;
        logic offset_comp;
        logic range_high;
    } fe_req_s;
endpackage

// ---- rtl/adc_interval_timer.sv ----
// interval timer counting only while run_in is high, pulsing when its count expires
// cleared by a synchronous restart; one clock domain
`timescale 1ns/1ps
module adc_interval_timer #(
    parameter int COUNT = 10240
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic restart_in,
    input wire logic run_in,
    output logic expire_out
);
    logic [31:0] count;
    wire last = (count == 32'(COUNT - 1));
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= 32'h0;
            expire_out <= 1'b0;
        end else begin
            expire_out <= run_in && !restart_in && last;
            if (restart_in || !run_in || last) begin
                count <= 32'h0;
            end else begin
                count <= count + 32'h1;
            end
        end
    end
endmodule

// ---- rtl/adc_sample_accum.sv ----
// per channel accumulator producing the mean of 1..16 samples
// samples arrive from the front end as unsigned or signed codes
`timescale 1ns/1ps
module adc_sample_accum #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic add_in,
    input wire logic is_signed_in,
    input wire logic [WIDTH-1:0] sample_in,
    input wire logic [2:0] shift_in,
    output logic [WIDTH-1:0] mean_out
);
    logic [WIDTH+3:0] sum;
    wire [WIDTH+3:0] ext = is_signed_in ? {{4{sample_in[WIDTH-1]}}, sample_in} : {4'h0, sample_in};
    // running sum plus the sample arriving now, so the mean is ready at the final sample
    wire [WIDTH+3:0] total = sum + ext;
    wire [WIDTH+3:0] shifted = is_signed_in ? (WIDTH+4)'($signed(total) >>> shift_in) : (total >> shift_in);
    assign mean_out = shifted[WIDTH-1:0];
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sum <= '0;
        end else if (clear_in) begin
            sum <= '0;
        end else if (add_in) begin
            sum <= sum + ext;
        end
    end
endmodule

// ---- rtl/adc_conversion_sequencer.sv ----
// sequencer for the six channel charger converter: modes, averaging, results
// register port synchronous to core_clk_in; front end answers with done and code
//
// How it works
// - single pass or pass repeating each second
// - single mode converts once then powers down
// - counter restarts continuous pass every second
// - front end unpowered between continuous passes
// - fixed sample rate, one two-bit depth
// - depth 2/4/8/16; otherwise one sample
// - averaging enable per channel, shared depth
// - averaged samples triggered every 256 us
// - offset compensation on channels 1,3,4
// - channel 0 bus voltage, range select
// - channel 1 bus current unsigned code
// - channel 2 battery voltage code
// - channel 3 battery current unsigned code
// - channel 4 external current signed code
// - channel 5 thermistor ratio code
// - registers on charger target address
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_conversion_sequencer #(
    parameter int SAMPLE_COUNT = `SAMPLE_CYCLES,
    parameter int PASS_COUNT = `PASS_CYCLES,
    parameter logic [7:0] TARGET_ADDR = `TARGET_ADDR_WR
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] target_addr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic fe_done_in,
    input wire logic [7:0] fe_code_in,
    output adc_seq_pkg::fe_req_s fe_req_out,
    output logic busy_out
);
    import adc_seq_pkg::*;

    // register port request bundle
    reg_req_s req;
    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
    // only the charger target address (write form, lsb cleared) reaches this block
    wire addr_match = ({target_addr_in[7:1], 1'b0} == TARGET_ADDR);

    logic [7:0] ctrl;
    logic [5:0] avg_en;
    logic [5:0] ofs_en;
    logic [7:0] result [`NUM_CHANNELS];
    logic [5:0] result_valid;
    seq_state_e state;
    logic [2:0] chan;
    logic [4:0] samples_done;
    logic fe_pending;

    wire enable = ctrl[`CTRL_ENABLE_BIT];
    wire cont_mode = ctrl[`CTRL_CONT_BIT];
    wire [1:0] depth_sel = ctrl[`CTRL_DEPTH_LSB +: 2];
    wire [2:0] shift = avg_en[chan] ? 3'(depth_sel) + 3'h1 : 3'h0;
    wire [4:0] need = 5'h1 << shift;
    wire wr_hit = req.wr && addr_match;
    wire rd_hit = req.rd && addr_match;
    wire wr_ctrl = wr_hit && (req.addr == `REG_CTRL);
    wire disable_now = wr_ctrl && !req.wdata[`CTRL_ENABLE_BIT];
    wire enable_now = wr_ctrl && req.wdata[`CTRL_ENABLE_BIT] && !enable;
    wire last_chan = (chan == 3'(`NUM_CHANNELS - 1));
    wire sample_last = (samples_done + 5'h1 == need);
    wire got_sample = (state == ST_CONVERT) && fe_pending && fe_done_in;
    wire chan_finish = got_sample && sample_last;
    wire pass_finish = chan_finish && last_chan;
    wire [7:0] mean;
    wire sample_tick;
    wire pass_tick;
    wire chan_signed = (chan == 3'h4);

    // 256 us spacing between averaged samples
    adc_interval_timer #(.COUNT(SAMPLE_COUNT)) u_sample_timer (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .restart_in(got_sample),
        .run_in(state == ST_WAIT_SAMPLE),
        .expire_out(sample_tick)
    );
    // one second pass interval, restarted by the enable write, held clear while enable or continuous mode is off, then wrapping on its own
    adc_interval_timer #(.COUNT(PASS_COUNT)) u_pass_timer (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .restart_in(enable_now),
        .run_in(enable && cont_mode),
        .expire_out(pass_tick)
    );
    adc_sample_accum #(.WIDTH(8)) u_accum (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(chan_finish || state == ST_IDLE || state == ST_SLEEP),
        .add_in(got_sample),
        .is_signed_in(chan_signed),
        .sample_in(fe_code_in),
        .shift_in(shift),
        .mean_out(mean)
    );
    // mean including the sample arriving now
    wire [7:0] stored = mean;

    // configuration registers, written on any matching port write whatever the sequencer state
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= `CTRL_RESET;
            avg_en <= 6'(`AVG_EN_RESET);
            ofs_en <= 6'(`OFS_EN_RESET);
        end else begin
            if (wr_ctrl) begin
                ctrl <= req.wdata;
            end else if (pass_finish && !cont_mode) begin
                ctrl[`CTRL_ENABLE_BIT] <= 1'b0;
            end
            if (wr_hit && req.addr == `REG_AVG_EN) begin
                avg_en <= req.wdata[5:0];
            end
            if (wr_hit && req.addr == `REG_OFS_EN) begin
                ofs_en <= req.wdata[5:0] & 6'(`OFS_CHAN_MASK);
            end
        end
    end

    // sequencer
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            chan <= 3'h0;
            samples_done <= 5'h0;
            fe_pending <= 1'b0;
        end else if (disable_now) begin
            state <= ST_IDLE;
            chan <= 3'h0;
            samples_done <= 5'h0;
            fe_pending <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (enable_now) begin
                        state <= ST_CONVERT;
                        fe_pending <= 1'b1;
                        chan <= 3'h0;
                        samples_done <= 5'h0;
                    end
                end
                ST_CONVERT: begin
                    if (got_sample) begin
                        fe_pending <= 1'b0;
                        if (!sample_last) begin
                            samples_done <= samples_done + 5'h1;
                            state <= ST_WAIT_SAMPLE;
                        end else if (!last_chan) begin
                            samples_done <= 5'h0;
                            chan <= chan + 3'h1;
                            fe_pending <= 1'b1;
                        end else begin
                            samples_done <= 5'h0;
                            chan <= 3'h0;
                            state <= cont_mode ? ST_SLEEP : ST_IDLE;
                        end
                    end
                end
                ST_WAIT_SAMPLE: begin
                    if (sample_tick) begin
                        state <= ST_CONVERT;
                        fe_pending <= 1'b1;
                    end
                end
                ST_SLEEP: begin
                    if (pass_tick) begin
                        state <= ST_CONVERT;
                        fe_pending <= 1'b1;
                    end
                end
            endcase
        end
    end

    // results: written only at each channel's final sample
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < `NUM_CHANNELS; i++) begin
                result[i] <= 8'h00;
            end
            result_valid <= 6'h00;
        end else if (chan_finish && !disable_now) begin
            result[chan] <= stored;
            result_valid[chan] <= 1'b1;
        end
    end

    // front end requests and register read data
    wire [7:0] status = {1'b0, (state == ST_IDLE) ? 1'b0 : 1'b1, result_valid};
    wire [7:0] rsel = req.addr - `REG_RESULT0;
    wire [7:0] rd_mux =
        (req.addr == `REG_CTRL) ? ctrl :
        (req.addr == `REG_AVG_EN) ? {2'b00, avg_en} :
        (req.addr == `REG_OFS_EN) ? {2'b00, ofs_en} :
        (req.addr == `REG_STATUS) ? status :
        (rsel < 8'(`NUM_CHANNELS)) ? result[rsel[2:0]] : 8'h00;
    wire fe_power = (state == ST_CONVERT) || (state == ST_WAIT_SAMPLE);
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
            fe_req_out <= '0;
            busy_out <= 1'b0;
        end else begin
            reg_rdata_out <= rd_hit ? rd_mux : 8'h00;
            fe_req_out.power_en <= fe_power && !disable_now;
            fe_req_out.start <= (state == ST_CONVERT) && fe_pending && !fe_done_in && !disable_now;
            fe_req_out.channel <= chan;
            fe_req_out.offset_comp <= ofs_en[chan];
            fe_req_out.range_high <= ctrl[`CTRL_RANGE_BIT];
            busy_out <= state != ST_IDLE;
        end
    end

    AST_OFS_ONLY_CURRENT: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (ofs_en & ~6'(`OFS_CHAN_MASK)) == 6'h00)
        else $error("offset compensation on a non-current channel");
    AST_SINGLE_STOPS: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (pass_finish && !cont_mode && !wr_ctrl) |=> (state == ST_IDLE) && !enable)
        else $error("single pass did not shut down");
    AST_CONT_SLEEPS: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (pass_finish && cont_mode && !wr_ctrl) |=> ##1 !fe_req_out.power_en)
        else $error("front end still powered after continuous pass");
    AST_SLEEP_WAKES: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (state == ST_SLEEP && pass_tick && !disable_now) |=> state == ST_CONVERT)
        else $error("pass interval expiry did not start a pass");
    AST_AVG_WAITS: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (got_sample && !sample_last && !disable_now) |=> state == ST_WAIT_SAMPLE)
        else $error("averaged channel did not wait for next sample");
    AST_NO_AVG_ONE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (state == ST_CONVERT && !avg_en[chan]) |-> need == 5'h1)
        else $error("non averaged channel needs more than one sample");
    AST_DEPTH_MAP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        avg_en[chan] |-> need == (5'h2 << depth_sel))
        else $error("averaging depth does not follow setting");
    AST_ABORT_IDLE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        disable_now |=> state == ST_IDLE && $stable(result_valid))
        else $error("disable did not abort the pass");
    AST_SINGLE_RESULT: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (chan_finish && !disable_now && !avg_en[chan]) |=> result[$past(chan)] == $past(fe_code_in))
        else $error("single sample result not stored");
endmodule

// ---- dv/fe_model.sv ----
// behavioural analog front end answering the sequencer's sample requests
// assumes one clock; code is channel base plus sample index plus bench bias
`timescale 1ns/1ps
module fe_model #(
    parameter logic [47:0] BASES = 48'h0
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire adc_seq_pkg::fe_req_s req_in,
    input wire logic [3:0] lat_in,
    input wire logic [7:0] bias_in,
    output logic done_out,
    output logic [7:0] code_out,
    output logic [5:0] ofs_seen_out,
    output logic range_seen_out,
    output int gap_out
);
    import adc_seq_pkg::*;
    logic [3:0] wait_cnt;
    logic [3:0] k;
    logic served;
    logic prev_start;
    logic [2:0] last_ch;
    int cyc;
    int last_rise;
    wire rise = req_in.start && !prev_start;
    wire same = req_in.channel == last_ch;
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {wait_cnt, k, served, prev_start, done_out, code_out} <= '0;
            {ofs_seen_out, range_seen_out, gap_out, cyc, last_rise} <= '0;
            last_ch <= 3'h7;
        end else begin
            cyc <= cyc + 1;
            prev_start <= req_in.start;
            done_out <= 1'b0;
            // released code lines toggle every cycle
            code_out <= ~code_out;
            if (!req_in.power_en) begin
                last_ch <= 3'h7;
            end
            if (rise) begin
                wait_cnt <= 4'h0;
                served <= 1'b0;
                k <= same ? k + 4'h1 : 4'h0;
                gap_out <= same ? cyc - last_rise : gap_out;
                last_rise <= cyc;
                last_ch <= req_in.channel;
                ofs_seen_out[req_in.channel] <= req_in.offset_comp;
                range_seen_out <= (req_in.channel == 3'h0) ? req_in.range_high : range_seen_out;
            end else if (req_in.start && req_in.power_en && !served) begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt + 4'h1 >= lat_in) begin
                    done_out <= 1'b1;
                    served <= 1'b1;
                    code_out <= BASES[req_in.channel*8 +: 8] + {4'h0, k} + bias_in;
                end
            end
        end
    end
endmodule

// ---- dv/adc_conversion_sequencer_bench.sv ----
// self-checking bench for the converter sequencer with a front end model
// assumes one 40 MHz clock and a register port driven on rising edges
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_conversion_sequencer_bench;
    import adc_seq_pkg::*;
    localparam int SC = 20;
    localparam int PC = 400;
    localparam logic [47:0] BASES = 48'hA0FE80604020;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] tgt = 8'hD2;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] bias = 8'h00;
    logic [3:0] lat = 4'h1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata, code;
    logic done, busy, rng_seen;
    logic [5:0] ofs_seen;
    fe_req_s req;
    int gap, bad_count = 0, checks = 0, rises = 0, last_rise = 0, pe_gap = 0, low_run = 0, low_max = 0, cyc = 0;
    adc_conversion_sequencer #(.SAMPLE_COUNT(SC), .PASS_COUNT(PC)) dut_u (
        .core_clk_in(clk), .rst_n_in(rst_n), .target_addr_in(tgt), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .fe_done_in(done), .fe_code_in(code), .fe_req_out(req), .busy_out(busy));
    fe_model #(.BASES(BASES)) fe_u (
        .core_clk_in(clk), .rst_n_in(rst_n), .req_in(req), .lat_in(lat), .bias_in(bias),
        .done_out(done), .code_out(code), .ofs_seen_out(ofs_seen), .range_seen_out(rng_seen),
        .gap_out(gap));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // pass spacing and analog-off time
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (req.power_en !== 1'b1) begin
            low_run <= low_run + 1;
        end else if (low_run > 0) begin
            pe_gap <= cyc - last_rise;
            last_rise <= cyc;
            rises <= rises + 1;
            low_max <= low_run;
            low_run <= 0;
        end
    end
    task automatic give_verdict;
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
        checks++;
        if (got !== expv) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, expv, got);
        end
    endtask
    task automatic rng(input string what, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] expv);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, expv, rdata);
    endtask
    task automatic wait_busy(input logic v, input int lim);
        for (int i = 0; i < lim && busy !== v; i++) begin
            @(posedge clk);
            #1;
        end
        if (busy !== v) begin
            chk("busy wait", v, busy);
            give_verdict();
        end
    endtask
    task automatic run_pass(input logic [7:0] ctrl);
        wreg(`REG_CTRL, ctrl);
        wait_busy(1'b1, 10);
        wait_busy(1'b0, 8000);
    endtask
    initial begin
        int d, ch, n, snap;
        logic [7:0] avg, expv;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rchk("ctrl reset", `REG_CTRL, `CTRL_RESET);
        rchk("avg reset", `REG_AVG_EN, `AVG_EN_RESET);
        rchk("ofs reset", `REG_OFS_EN, `OFS_EN_RESET);
        rchk("unmapped", 8'h5A, 8'h00);
        tgt <= 8'h4A;
        wreg(`REG_AVG_EN, 8'h3F);
        rchk("foreign read", `REG_AVG_EN, 8'h00);
        tgt <= 8'hD3;
        rchk("foreign write", `REG_AVG_EN, 8'h00);
        wreg(`REG_OFS_EN, 8'h3F);
        rchk("ofs mask", `REG_OFS_EN, `OFS_CHAN_MASK);
        run_pass(8'h11);
        chk("offset seen", `OFS_CHAN_MASK, ofs_seen);
        chk("range high", 1, rng_seen);
        rchk("enable cleared", `REG_CTRL, 8'h10);
        rchk("status", `REG_STATUS, 8'h3F);
        chk("power off", 0, req.power_en);
        snap = rises;
        repeat (500) @(posedge clk);
        chk("no rerun", snap, rises);
        wreg(`REG_OFS_EN, 8'h00);
        run_pass(8'h01);
        chk("offset off", 0, ofs_seen);
        chk("range low", 0, rng_seen);
        // every depth, mixed and full averaging masks, prompt and slow front end
        for (d = 0; d < 4; d++) begin
            avg = d[0] ? 8'h3F : 8'h15;
            bias <= 8'(d);
            lat <= d[0] ? 4'h1 : 4'h9;
            wreg(`REG_AVG_EN, avg);
            run_pass(8'h01 | 8'(d << 2));
            chk("sample gap", 32'(SC + 4 + int'(lat)), gap);
            for (ch = 0; ch < 6; ch++) begin
                n = avg[ch] ? (2 << d) : 1;
                expv = BASES[ch*8 +: 8] + 8'((n - 1) >> 1) + 8'(d);
                rchk("result", 8'(`REG_RESULT0 + ch), expv);
            end
        end
        wreg(`REG_AVG_EN, 8'h00);
        wreg(`REG_CTRL, 8'h03);
        repeat (PC * 3 + 50) @(posedge clk);
        chk("pass period", PC, pe_gap);
        rng("analog off", PC - 100, PC - 1, low_max);
        wreg(`REG_CTRL, 8'h00);
        wait_busy(1'b0, 20);
        expv = BASES[7:0] + 8'h03;
        bias <= 8'h40;
        lat <= 4'h9;
        wreg(`REG_AVG_EN, 8'h3F);
        wreg(`REG_CTRL, 8'h0D);
        repeat (100) @(posedge clk);
        #1;
        chk("mid pass", 1, req.power_en);
        wreg(`REG_CTRL, 8'h00);
        repeat (4) @(posedge clk);
        #1;
        chk("abort power", 0, req.power_en);
        chk("abort busy", 0, busy);
        rchk("abort result", `REG_RESULT0, expv);
        give_verdict();
    end
endmodule
